// ### shared/smw_defs.svh
// Functional notes
// R1: Without float optimization, float wait cycles follow a read before the next access.
// R2: Float cycles already covered by the controlling strobe hold are not added again.
// R3: Wait select 10 is frozen, 11 is ready, 00 ignores the wait input.
// R4: Wait stretches the access around the controlling strobe chosen by the mode bits.
// R5: Software gives controlling strobes at least one hold cycle when wait is enabled.
// R6: Software never combines wait with page mode or slow clock mode.
// R7: Wait is looked at only during the controlling strobe pulse phase.
// R8: Frozen mode stalls all counters and control outputs, then resumes where stopped.
// R9: Ready mode counts setup and pulse normally, checks wait only at last pulse cycle.
// R10: Ready mode suspends at that cycle while wait is low, then performs the hold.
// R11: Ready mode ignores wait released before or raised after the pulse end.
// R12: Software programs pulse length at least wait latency plus three cycles.
// R13: Slow clock indication forces fixed waveforms on every chip select.
// R14: Slow reads: strobe setup 1 pulse 1, select setup 0 pulse 2, total 2.
// R15: Slow writes: strobe setup 1 pulse 1, select setup 0 pulse 3, total 3.
// R16: A transfer under way keeps the slow parameter set after slow mode ends.
// R17: Page burst reads only with page enable; size select gives 4, 8, 16, 32 bytes.
// R18: Pages are size aligned; bits above page size form the page address.
// R19: First page access uses select read pulse, later hits use read strobe pulse.
// R20: In page mode strobe and select stay low together, setup, hold and total ignored.
// R21: Page pulse lengths are applied as given, with no consistency check.
// R22: Page hit needs same chip select, same page address, no other access between.
// R23: Float count field gives 0 to 15 cycles of bus release time.
// R24: One extra idle cycle always separates a read from a following write.
// R25: The wait input passes a two flop synchroniser before use.
`ifndef SMW_DEFS_SVH
`define SMW_DEFS_SVH
`define WAIT_SEL_FROZEN  2'h2
`define WAIT_SEL_READY   2'h3
`define SLOW_STB_SETUP   9'h001
`define SLOW_STB_PULSE   9'h001
`define SLOW_CS_SETUP    9'h000
`define SLOW_RD_CS_PULSE 9'h002
`define SLOW_RD_TOTAL    9'h002
`define SLOW_WR_CS_PULSE 9'h003
`define SLOW_WR_TOTAL    9'h003
`define PAGE_LSB_BASE    5'h02
`define RD_WR_IDLE       5'h01
`define CS_SWITCH_IDLE   5'h01
`define WAIT_SYNC_RST    1'b1
`endif

// ### shared/smw_pkg.sv
package smw_pkg;
	// Per chip select settings, lengths already in cycles
	typedef struct packed {
		logic [8:0] read_strobe_setup_len;
		logic [8:0] read_strobe_pulse_len;
		logic [8:0] cs_read_setup_len;
		logic [8:0] cs_read_pulse_len;
		logic [8:0] read_total_len;
		logic [8:0] write_strobe_setup_len;
		logic [8:0] write_strobe_pulse_len;
		logic [8:0] cs_write_setup_len;
		logic [8:0] cs_write_pulse_len;
		logic [8:0] write_total_len;
		logic       read_ctrl_strobe;
		logic       write_ctrl_strobe;
		logic [1:0] ext_wait_select;
		logic [3:0] float_cycles;
		logic       float_opt;
		logic       page_mode_enable;
		logic [1:0] page_size_sel;
	} cs_cfg_t;

	// Waveform set latched for the access in progress
	typedef struct packed {
		logic [8:0] stb_setup;
		logic [8:0] stb_pulse;
		logic [8:0] cs_setup;
		logic [8:0] cs_pulse;
		logic [8:0] total;
		logic       ctrl_stb;
		logic [1:0] wait_sel;
		logic       page;
	} timing_t;

	typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_ACCESS} state_t;
endpackage

// ### hw/static_mem_wait_slowclk_page.sv
`timescale 1ns/100ps
`include "smw_defs.svh"
module static_mem_wait_slowclk_page (
	input  wire logic                     core_clk_i,
	input  wire logic                     rst_i,
	input  wire smw_pkg::cs_cfg_t [3:0]   cs_cfg_i,
	input  wire logic                     slow_clk_mode_i,
	input  wire logic                     req_valid_i,
	input  wire logic                     req_write_i,
	input  wire logic [1:0]               req_cs_i,
	input  wire logic [23:0]              req_addr_i,
	input  wire logic                     ext_wait_n_i,
	output logic                          req_ready_o,
	output logic                          done_o,
	output logic [23:0]                   addr_o,
	output logic [3:0]                    chip_select_n_o,
	output logic                          read_strobe_n_o,
	output logic                          write_strobe_n_o
);
	smw_pkg::state_t  state_q, state_d;
	smw_pkg::timing_t t_q, t_d;
	smw_pkg::cs_cfg_t cfg;
	logic [8:0]  cnt_q, cnt_d;
	logic [4:0]  gap_q, gap_d, gap_c;
	logic [4:0]  float_q, float_d;
	logic        wr_q, wr_d, last_rd_q, last_rd_d, had_q, had_d;
	logic [1:0]  cs_q, cs_d;
	logic [23:0] addr_q, addr_d, page_tag_q, page_tag_d, pmask;
	logic        page_ok_q, page_ok_d, hit;
	logic        ws1_q, ws2_q;
	logic        stb_on, cs_on, in_pulse, last_pulse, stall, fin;
	logic [9:0]  c_end, hold;
	logic [8:0]  c_setup, c_pulse;
	logic        ready_d, done_d, rd_n_d, wr_n_d;
	logic [3:0]  cs_n_d;

	// True while the count sits inside a setup plus pulse window
	function automatic logic win(input logic [8:0] c, input logic [8:0] s, input logic [8:0] p);
		win = ({1'b0, c} >= {1'b0, s}) && ({1'b0, c} < ({1'b0, s} + {1'b0, p}));
	endfunction

	// Wait synchroniser; first stage feeds only the second
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ws1_q <= `WAIT_SYNC_RST;
			ws2_q <= `WAIT_SYNC_RST;
		end else begin
			ws1_q <= ext_wait_n_i; // see R25
			ws2_q <= ws1_q;
		end
	end

	// Controlling strobe window and wait decisions for the running access
	always_comb begin
		c_setup    = t_q.ctrl_stb ? t_q.stb_setup : t_q.cs_setup; // see R4
		c_pulse    = t_q.ctrl_stb ? t_q.stb_pulse : t_q.cs_pulse;
		c_end      = {1'b0, c_setup} + {1'b0, c_pulse};
		in_pulse   = win(cnt_q, c_setup, c_pulse); // see R7
		last_pulse = ({1'b0, cnt_q} + 10'h001) == c_end;
		// Ready check also needs in_pulse: a zero pulse has no last pulse cycle
		stall      = 1'b0;
		if (state_q == smw_pkg::ST_ACCESS && !ws2_q && !t_q.page) begin
			if (t_q.wait_sel == `WAIT_SEL_FROZEN && in_pulse)
				stall = 1'b1; // see R8
			else if (t_q.wait_sel == `WAIT_SEL_READY && last_pulse && in_pulse)
				stall = 1'b1; // see R9 see R10 see R11
		end
		fin  = ({1'b0, cnt_q} + 10'h001) >= {1'b0, t_q.total};
		// Hold already spent counts against the float time
		hold = ({1'b0, t_q.total} > c_end) ? ({1'b0, t_q.total} - c_end) : 10'h000; // see R2
	end

	// Page address compare against the selected chip select
	always_comb begin
		cfg   = cs_cfg_i[req_cs_i];
		pmask = 24'hFFFFFF << (`PAGE_LSB_BASE + {3'h0, cfg.page_size_sel}); // see R17 see R18
		hit   = page_ok_q && (cs_q == req_cs_i)
			&& ((page_tag_q & pmask) == (req_addr_i & pmask)); // see R22
		gap_c = float_q;
		if (had_q && last_rd_q && req_write_i)
			gap_c = gap_c + `RD_WR_IDLE; // see R24
		if (had_q && cs_q != req_cs_i)
			gap_c = gap_c + `CS_SWITCH_IDLE;
	end

	// Sequencer next state
	always_comb begin
		state_d    = state_q;
		t_d        = t_q;
		cnt_d      = cnt_q;
		gap_d      = gap_q;
		float_d    = float_q;
		wr_d       = wr_q;
		last_rd_d  = last_rd_q;
		had_d      = had_q;
		cs_d       = cs_q;
		addr_d     = addr_q;
		page_tag_d = page_tag_q;
		page_ok_d  = page_ok_q;
		done_d     = 1'b0;
		case (state_q)
			smw_pkg::ST_IDLE: begin
				if (req_valid_i && req_ready_o) begin
					wr_d   = req_write_i;
					cs_d   = req_cs_i;
					addr_d = req_addr_i;
					cnt_d  = 9'h000;
					t_d.ctrl_stb = req_write_i ? cfg.write_ctrl_strobe : cfg.read_ctrl_strobe;
					t_d.wait_sel = cfg.ext_wait_select; // see R3
					t_d.page     = 1'b0;
					if (slow_clk_mode_i) begin
						// Fixed set, kept until the access ends
						t_d.stb_setup = `SLOW_STB_SETUP; // see R13 see R16
						t_d.stb_pulse = `SLOW_STB_PULSE;
						t_d.cs_setup  = `SLOW_CS_SETUP;
						t_d.cs_pulse  = req_write_i ? `SLOW_WR_CS_PULSE : `SLOW_RD_CS_PULSE; // see R14
						t_d.total     = req_write_i ? `SLOW_WR_TOTAL : `SLOW_RD_TOTAL; // see R15
						t_d.wait_sel  = 2'h0;
					end else if (!req_write_i && cfg.page_mode_enable) begin
						// Strobe and select share one window, no setup or hold
						t_d.page      = 1'b1; // see R20
						t_d.stb_setup = 9'h000;
						t_d.cs_setup  = 9'h000;
						t_d.stb_pulse = hit ? cfg.read_strobe_pulse_len : cfg.cs_read_pulse_len; // see R19 see R21
						t_d.cs_pulse  = t_d.stb_pulse;
						t_d.total     = t_d.stb_pulse;
					end else if (req_write_i) begin
						t_d.stb_setup = cfg.write_strobe_setup_len;
						t_d.stb_pulse = cfg.write_strobe_pulse_len;
						t_d.cs_setup  = cfg.cs_write_setup_len;
						t_d.cs_pulse  = cfg.cs_write_pulse_len;
						t_d.total     = cfg.write_total_len;
					end else begin
						t_d.stb_setup = cfg.read_strobe_setup_len;
						t_d.stb_pulse = cfg.read_strobe_pulse_len;
						t_d.cs_setup  = cfg.cs_read_setup_len;
						t_d.cs_pulse  = cfg.cs_read_pulse_len;
						t_d.total     = cfg.read_total_len;
					end
					page_ok_d  = t_d.page;
					page_tag_d = req_addr_i;
					float_d    = 5'h00;
					if (gap_c != 5'h00) begin
						gap_d   = gap_c; // see R1
						state_d = smw_pkg::ST_GAP;
					end else begin
						state_d = smw_pkg::ST_ACCESS;
					end
				end
			end
			smw_pkg::ST_GAP: begin
				gap_d = gap_q - 5'h01;
				if (gap_q == 5'h01)
					state_d = smw_pkg::ST_ACCESS;
			end
			smw_pkg::ST_ACCESS: begin
				if (!stall) begin
					if (fin) begin
						state_d   = smw_pkg::ST_IDLE;
						done_d    = 1'b1;
						had_d     = 1'b1;
						last_rd_d = !wr_q;
						// Optimized float leaves float_d at zero, so no float cycles follow
						if (!wr_q && !cfg_float_opt() && {6'h00, float_cfg()} > hold)
							float_d = float_cfg() - hold[4:0]; // see R1 see R23
					end else begin
						cnt_d = cnt_q + 9'h001;
					end
				end
			end
			default: state_d = smw_pkg::ST_IDLE;
		endcase
	end

	// Float settings of the chip select that just finished
	function automatic logic [4:0] float_cfg();
		float_cfg = {1'b0, cs_cfg_i[cs_q].float_cycles};
	endfunction
	function automatic logic cfg_float_opt();
		cfg_float_opt = cs_cfg_i[cs_q].float_opt;
	endfunction

	// Pin levels from the next state so outputs leave flip-flops
	always_comb begin
		stb_on  = (state_d == smw_pkg::ST_ACCESS) && win(cnt_d, t_d.stb_setup, t_d.stb_pulse);
		cs_on   = (state_d == smw_pkg::ST_ACCESS) && win(cnt_d, t_d.cs_setup, t_d.cs_pulse);
		rd_n_d  = !(stb_on && !wr_d);
		wr_n_d  = !(stb_on && wr_d);
		cs_n_d  = 4'hF;
		if (cs_on)
			cs_n_d[cs_d] = 1'b0;
		ready_d = (state_d == smw_pkg::ST_IDLE);
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q          <= smw_pkg::ST_IDLE;
			t_q              <= '0;
			cnt_q            <= 9'h000;
			gap_q            <= 5'h00;
			float_q          <= 5'h00;
			wr_q             <= 1'b0;
			last_rd_q        <= 1'b0;
			had_q            <= 1'b0;
			cs_q             <= 2'h0;
			addr_q           <= 24'h000000;
			page_tag_q       <= 24'h000000;
			page_ok_q        <= 1'b0;
			req_ready_o      <= 1'b1;
			done_o           <= 1'b0;
			addr_o           <= 24'h000000;
			chip_select_n_o  <= 4'hF;
			read_strobe_n_o  <= 1'b1;
			write_strobe_n_o <= 1'b1;
		end else begin
			state_q          <= state_d;
			t_q              <= t_d;
			cnt_q            <= cnt_d;
			gap_q            <= gap_d;
			float_q          <= float_d;
			wr_q             <= wr_d;
			last_rd_q        <= last_rd_d;
			had_q            <= had_d;
			cs_q             <= cs_d;
			addr_q           <= addr_d;
			page_tag_q       <= page_tag_d;
			page_ok_q        <= page_ok_d;
			req_ready_o      <= ready_d;
			done_o           <= done_d;
			addr_o           <= addr_d;
			chip_select_n_o  <= cs_n_d;
			read_strobe_n_o  <= rd_n_d;
			write_strobe_n_o <= wr_n_d;
		end
	end

	// Checks share the core clock and stay quiet during reset
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	property p_sync;
		##2 1 |-> ws2_q == $past(ext_wait_n_i, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("wait sync depth wrong"); // see R25

	property p_frozen;
		state_q == smw_pkg::ST_ACCESS && !t_q.page && t_q.wait_sel == `WAIT_SEL_FROZEN
			&& in_pulse && !ws2_q |=> $stable(cnt_q) && $stable(chip_select_n_o)
			&& $stable(read_strobe_n_o) && $stable(write_strobe_n_o);
	endproperty
	a_frozen: assert property (p_frozen) else $error("frozen stall broken"); // see R8

	property p_ready;
		state_q == smw_pkg::ST_ACCESS && !t_q.page && t_q.wait_sel == `WAIT_SEL_READY
			&& last_pulse && !ws2_q |=> state_q == smw_pkg::ST_ACCESS && $stable(cnt_q);
	endproperty
	a_ready: assert property (p_ready) else $error("ready suspend broken"); // see R10

	property p_outside;
		state_q == smw_pkg::ST_ACCESS && !in_pulse && !fin |=> cnt_q == $past(cnt_q) + 9'h001;
	endproperty
	a_outside: assert property (p_outside) else $error("wait acted outside pulse"); // see R7

	property p_slow;
		state_q == smw_pkg::ST_IDLE && req_valid_i && slow_clk_mode_i
			|=> t_q.stb_setup == 9'h001 && t_q.stb_pulse == 9'h001 && t_q.cs_setup == 9'h000
			&& t_q.total == (wr_q ? 9'h003 : 9'h002) && t_q.cs_pulse == t_q.total;
	endproperty
	a_slow: assert property (p_slow) else $error("slow waveform set wrong"); // see R14

	property p_rw_gap;
		state_q == smw_pkg::ST_IDLE && req_valid_i && req_write_i && had_q && last_rd_q
			|=> state_q == smw_pkg::ST_GAP;
	endproperty
	a_rw_gap: assert property (p_rw_gap) else $error("read to write idle missing"); // see R24

	property p_gap;
		state_q == smw_pkg::ST_GAP && gap_q == 5'h01 |=> state_q == smw_pkg::ST_ACCESS;
	endproperty
	a_gap: assert property (p_gap) else $error("gap length wrong"); // see R1

	property p_page_pins;
		state_q == smw_pkg::ST_ACCESS && t_q.page && !wr_q
			|-> read_strobe_n_o == chip_select_n_o[cs_q];
	endproperty
	a_page_pins: assert property (p_page_pins) else $error("page strobes differ"); // see R20

	property p_page_len;
		state_q == smw_pkg::ST_IDLE && req_valid_i && !req_write_i && !slow_clk_mode_i
			&& cfg.page_mode_enable && hit
			|=> t_q.total == $past(cfg.read_strobe_pulse_len);
	endproperty
	a_page_len: assert property (p_page_len) else $error("page hit length wrong"); // see R19

	// Main scenarios the bench is expected to reach
	c_frozen: cover property (state_q == smw_pkg::ST_ACCESS && stall
		&& t_q.wait_sel == `WAIT_SEL_FROZEN);
	c_ready: cover property (state_q == smw_pkg::ST_ACCESS && stall
		&& t_q.wait_sel == `WAIT_SEL_READY);
	c_page_hit: cover property (state_q == smw_pkg::ST_IDLE && req_valid_i && hit);
	c_slow_wr: cover property (state_q == smw_pkg::ST_IDLE && req_valid_i && req_write_i
		&& slow_clk_mode_i);
endmodule

// ### verif/mem_wait_partner.sv
`timescale 1ns/100ps
// Memory side wait behaviour; wait line has a pull-up, so released means high
module mem_wait_partner (
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	input  wire logic [3:0] chip_select_n_i,
	input  wire logic       read_strobe_n_i,
	input  wire logic       write_strobe_n_i,
	input  wire logic [1:0] mode_i,
	input  wire logic [3:0] len_i,
	output logic            ext_wait_n_o
);
	logic       stb_low;
	logic       cs_low;
	logic [7:0] cnt_q;
	logic       seen_q;

	assign stb_low = !read_strobe_n_i || !write_strobe_n_i;
	assign cs_low  = !(&chip_select_n_i);

	// Cycles since the strobe fell, and whether this select has pulsed yet
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q  <= 8'h00;
			seen_q <= 1'b0;
		end else begin
			cnt_q  <= stb_low ? ((cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01) : 8'h00;
			seen_q <= cs_low && (seen_q || stb_low);
		end
	end

	// Mode 1 answers the strobe at once; mode 2 asserts only in the hold phase
	assign ext_wait_n_o = !((mode_i == 2'h1 && stb_low && cnt_q < {4'h0, len_i}) ||
		(mode_i == 2'h2 && seen_q && !stb_low && cs_low));
endmodule

// ### verif/static_mem_wait_slowclk_page_bench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
	$display("FAIL %0t got %0h exp %0h", $time, (a), (b)); end end
module static_mem_wait_slowclk_page_bench;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	smw_pkg::cs_cfg_t [3:0] cfg = '0;
	logic slow_clk_mode_i = 1'b0;
	logic req_valid_i = 1'b0;
	logic req_write_i = 1'b0;
	logic [1:0] req_cs_i = 2'h0;
	logic [23:0] req_addr_i = 24'h000000;
	logic use_rand = 1'b1;
	logic rnd_w = 1'b1;
	logic [1:0] pmode = 2'h0;
	logic [3:0] plen = 4'h5;
	logic part_w;
	logic req_ready_o;
	logic done_o;
	logic [23:0] addr_o;
	logic [3:0] chip_select_n_o;
	logic read_strobe_n_o;
	logic write_strobe_n_o;
	logic [31:0] seed = 32'h00000053;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	int e_low;
	int p_float;
	int p_cs;
	logic p_rd;
	logic p_page;
	logic [23:0] p_addr;

	always #25 core_clk_i = !core_clk_i;

	static_mem_wait_slowclk_page dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .cs_cfg_i(cfg),
		.slow_clk_mode_i(slow_clk_mode_i), .req_valid_i(req_valid_i),
		.req_write_i(req_write_i), .req_cs_i(req_cs_i), .req_addr_i(req_addr_i),
		.ext_wait_n_i(use_rand ? rnd_w : part_w), .req_ready_o(req_ready_o),
		.done_o(done_o), .addr_o(addr_o), .chip_select_n_o(chip_select_n_o),
		.read_strobe_n_o(read_strobe_n_o), .write_strobe_n_o(write_strobe_n_o));
	mem_wait_partner mem (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.chip_select_n_i(chip_select_n_o), .read_strobe_n_i(read_strobe_n_o),
		.write_strobe_n_i(write_strobe_n_o), .mode_i(pmode), .len_i(plen),
		.ext_wait_n_o(part_w));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Legal timings only: total covers every setup plus pulse
	function automatic smw_pkg::cs_cfg_t rand_cfg();
		smw_pkg::cs_cfg_t c;
		c = '0;
		c.read_strobe_setup_len = 9'(rnd() % 4);
		c.read_strobe_pulse_len = 9'(1 + rnd() % 4);
		c.cs_read_setup_len = 9'(rnd() % 3);
		c.cs_read_pulse_len = 9'(1 + rnd() % 5);
		c.read_total_len = 9'(8 + rnd() % 3);
		c.write_strobe_setup_len = 9'(rnd() % 4);
		c.write_strobe_pulse_len = 9'(1 + rnd() % 4);
		c.cs_write_setup_len = 9'(rnd() % 3);
		c.cs_write_pulse_len = 9'(1 + rnd() % 5);
		c.write_total_len = 9'(8 + rnd() % 3);
		c.read_ctrl_strobe = 1'(rnd());
		c.write_ctrl_strobe = 1'(rnd());
		c.float_cycles = 4'(rnd());
		c.float_opt = 1'(rnd());
		return c;
	endfunction

	// Cycles from acceptance to done, tracking float, turnaround and page state
	function automatic int exp_cycles(input logic wr, input logic [1:0] cs,
		input logic [23:0] a, input logic sl);
		smw_pkg::cs_cfg_t c;
		int tot;
		int cp;
		int g;
		int lsb;
		logic pg;
		logic hit;
		c = cfg[cs];
		lsb = 2 + c.page_size_sel;
		pg = !wr && !sl && c.page_mode_enable;
		hit = pg && p_page && (cs == p_cs) && ((a >> lsb) == (p_addr >> lsb));
		// No select switch idle before the first access after reset
		g = p_float + ((p_rd && wr) ? 1 : 0) + ((p_cs >= 0 && cs != p_cs) ? 1 : 0);
		e_low = -1;
		if (sl) begin
			tot = wr ? 3 : 2;
			cp = 2;
			e_low = 1;
		end else if (pg) begin
			tot = hit ? c.read_strobe_pulse_len : c.cs_read_pulse_len;
			cp = tot;
			e_low = tot;
		end else begin
			tot = wr ? c.write_total_len : c.read_total_len;
			cp = c.read_ctrl_strobe ? c.read_strobe_setup_len + c.read_strobe_pulse_len :
				c.cs_read_setup_len + c.cs_read_pulse_len;
		end
		p_float = (!wr && !c.float_opt && c.float_cycles > tot - cp) ?
			c.float_cycles - (tot - cp) : 0;
		p_rd = !wr;
		p_cs = cs;
		p_page = pg;
		p_addr = a;
		return 1 + g + tot;
	endfunction

	task automatic end_sim();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic do_reset();
		rst_i = 1'b1;
		repeat (12) @(negedge core_clk_i);
		rst_i = 1'b0;
		p_float = 0;
		p_cs = -1;
		p_rd = 1'b0;
		p_page = 1'b0;
		@(negedge core_clk_i);
		`CHK({req_ready_o, done_o, chip_select_n_o, read_strobe_n_o, write_strobe_n_o}, 8'hBF)
	endtask

	// One access; slow indication dropped right after acceptance
	task automatic do_req(input logic wr, input logic [1:0] cs, input logic [23:0] a,
		input logic sl, input int extra);
		int e;
		int n;
		int lowc;
		logic [31:0] t;
		e = exp_cycles(wr, cs, a, sl) + extra;
		lowc = 0;
		while (req_ready_o !== 1'b1) @(negedge core_clk_i);
		req_valid_i = 1'b1;
		req_write_i = wr;
		req_cs_i = cs;
		req_addr_i = a;
		slow_clk_mode_i = sl;
		@(negedge core_clk_i);
		req_valid_i = 1'b0;
		slow_clk_mode_i = 1'b0;
		n = 1;
		while (done_o !== 1'b1 && n < 400) begin
			if (read_strobe_n_o === 1'b0 || write_strobe_n_o === 1'b0) lowc++;
			t = rnd();
			rnd_w = t[0];
			@(negedge core_clk_i);
			n++;
		end
		`CHK(n, e)
		if (e_low >= 0) `CHK(lowc, e_low)
		`CHK(addr_o, a)
	endtask

	// Hang guard well above the expected run length
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_sim();
		end
	end

	initial begin
		logic [1:0] sel [3];
		sel = '{2'h0, 2'h2, 2'h3};
		for (int i = 0; i < 4; i++) cfg[i] = rand_cfg();
		do_reset();
		repeat (60) do_req(1'(rnd()), 2'(rnd()), 24'(rnd()), 1'b0, 0);
		repeat (10) do_req(1'(rnd()), 2'(rnd()), 24'(rnd()), 1'b1, 0);
		for (int i = 0; i < 4; i++) cfg[i].float_cycles = 4'h0;
		cfg[2] = '0;
		cfg[2].read_strobe_setup_len = 9'h001;
		cfg[2].read_strobe_pulse_len = 9'h004;
		cfg[2].cs_read_pulse_len = 9'h007;
		cfg[2].read_total_len = 9'h007;
		cfg[2].write_strobe_setup_len = 9'h001;
		cfg[2].write_strobe_pulse_len = 9'h004;
		cfg[2].cs_write_pulse_len = 9'h007;
		cfg[2].write_total_len = 9'h007;
		cfg[2].read_ctrl_strobe = 1'b1;
		cfg[2].write_ctrl_strobe = 1'b1;
		cfg[1] = cfg[2];
		cfg[1].page_mode_enable = 1'b1;
		cfg[1].page_size_sel = 2'h1;
		cfg[1].cs_read_pulse_len = 9'h002;
		cfg[1].read_strobe_pulse_len = 9'h005;
		use_rand = 1'b0;
		do_reset();
		pmode = 2'h1;
		for (int s = 0; s < 3; s++) begin
			cfg[2].ext_wait_select = sel[s];
			for (int w = 0; w < 2; w++) begin
				do_req(w[0], 2'h2, 24'h000040, 1'b0, (s == 0) ? 0 : ((s == 1) ? 5 : 4));
			end
		end
		pmode = 2'h2;
		for (int s = 1; s < 3; s++) begin
			cfg[2].ext_wait_select = sel[s];
			do_req(1'b0, 2'h2, 24'h000044, 1'b0, 0);
		end
		pmode = 2'h0;
		cfg[2].ext_wait_select = 2'h0;
		do_req(1'b0, 2'h1, 24'h000120, 1'b0, 0);
		do_req(1'b0, 2'h1, 24'h000125, 1'b0, 0);
		do_req(1'b0, 2'h1, 24'h000128, 1'b0, 0);
		do_req(1'b0, 2'h1, 24'h00012F, 1'b0, 0);
		do_req(1'b0, 2'h2, 24'h00012F, 1'b0, 0);
		do_req(1'b0, 2'h1, 24'h00012F, 1'b0, 0);
		do_req(1'b1, 2'h1, 24'h00012E, 1'b0, 0);
		end_sim();
	end
endmodule
